// >>> logic/host_processor_port.sv
// Purpose: Parallel 16-bit host port with two strobe protocols and an interrupt pulse
// Assumes: Host pins arrive asynchronously and are synchronised to REF_CLK
// Notes: Read data comes from the core on READ_DATA for the address on TARGET_ADDR
//
// Summary of operation
// - Host data bus is 16 bits, bidirectional, bit 15 most significant.
// - Address is three bits; bit 2 is reserved and ignored.
// - Mode low: write strobe rising edge with select low performs the write transfer.
// - Mode high, direction low: data strobe rising edge performs the write transfer.
// - Mode high, direction high: drive read data while data strobe is low.
// - Mode low: drive read data only while read strobe and select are low.
// - Mode pin selects protocol; an undriven pin means separate strobes.
// - New channel data pulses the interrupt for a programmable number of clocks.
`timescale 1ns/10ps
module host_processor_port
    import host_port_pkg::*;
#(
    parameter int DW = DATA_W
) (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic [DW-1:0] P_IN,
    output logic [DW-1:0] P_OUT,
    output logic P_OE,
    input wire logic [ADDR_W-1:0] ADD,
    input wire logic WR_N,
    input wire logic RD_N,
    input wire logic CE_N,
    input wire logic UP_MODE,
    input wire logic XFER_SEL,
    output logic [DW-1:0] HOLD_DATA,
    output logic [ADDR_USED_W-1:0] TARGET_ADDR,
    output logic HOLD_LOAD,
    output logic TARGET_WRITE,
    input wire logic [DW-1:0] READ_DATA,
    output logic READ_ACTIVE,
    input wire logic NEW_DATA,
    input wire logic [PULSE_W-1:0] PULSE_LEN,
    output logic NEW_DATA_INTERRUPT
);
    // Only the 16-bit bus is served, and at least one address bit must be reserved
    if (DW != DATA_W) begin : g_dw_check
        $error("host_processor_port DW must equal 16");
    end
    if (ADDR_W <= ADDR_USED_W) begin : g_addr_check
        $error("host_processor_port needs at least one reserved address bit");
    end

    // Low while the write strobe of the protocol is active; combined mode needs direction low
    function automatic logic write_strobe_n(input logic mode, input logic wr_n, input logic rd_n);
        if (mode) begin
            return wr_n | rd_n;
        end else begin
            return wr_n;
        end
    endfunction

    // High while the read conditions of the protocol hold; select low is needed in both
    function automatic logic read_request(input logic mode, input logic ce_n, input logic wr_n, input logic rd_n);
        if (mode) begin
            return ~wr_n & rd_n & ~ce_n;
        end else begin
            return ~rd_n & ~ce_n;
        end
    endfunction

    // Reserved top address bit is dropped here
    function automatic logic [ADDR_USED_W-1:0] target_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_USED_W-1:0];
    endfunction

    // Two-stage synchronisers; stage one feeds only stage two
    logic [DW-1:0] p_s1_q;
    logic [DW-1:0] p_s2_q;
    logic [ADDR_W-1:0] add_s1_q;
    logic [ADDR_W-1:0] add_s2_q;
    logic [4:0] ctl_s1_q;
    logic [4:0] ctl_s2_q;
    logic [4:0] ctl_raw;

    // Pulled-down pin: an undriven mode reads low, the separate-strobe protocol
    assign ctl_raw = {UP_MODE, CE_N, WR_N, RD_N, XFER_SEL};

    // Bus bits may skew; they are used only after the strobe edge has passed the same depth
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            p_s1_q <= HOLD_RESET;
            p_s2_q <= HOLD_RESET;
        end else begin
            p_s1_q <= P_IN;
            p_s2_q <= p_s1_q;
        end
    end

    // Address has the same timing as select, so it settles with the strobes
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            add_s1_q <= '0;
            add_s2_q <= '0;
        end else begin
            add_s1_q <= ADD;
            add_s2_q <= add_s1_q;
        end
    end

    // Control resets to the idle pin levels so no false strobe edge follows reset
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctl_s1_q <= CTL_IDLE;
            ctl_s2_q <= CTL_IDLE;
        end else begin
            ctl_s1_q <= ctl_raw;
            ctl_s2_q <= ctl_s1_q;
        end
    end

    logic mode_s, ce_n_s, wr_n_s, rd_n_s, sel_s;
    assign {mode_s, ce_n_s, wr_n_s, rd_n_s, sel_s} = ctl_s2_q;

    // Strobe that ends a write and the level that marks a read, per protocol
    logic wr_strobe_n;
    logic rd_req;
    assign wr_strobe_n = write_strobe_n(mode_s, wr_n_s, rd_n_s);
    assign rd_req = read_request(mode_s, ce_n_s, wr_n_s, rd_n_s);

    access_state_type state_q, state_d;
    logic [DW-1:0] hold_q, hold_d;
    logic [ADDR_USED_W-1:0] addr_q, addr_d;
    logic [DW-1:0] rdata_q, rdata_d;
    logic load_q, load_d;
    logic twr_q, twr_d;
    logic oe_q, oe_d;

    always_comb begin
        state_d = state_q;
        hold_d = hold_q;
        addr_d = addr_q;
        rdata_d = rdata_q;
        load_d = 1'b0;
        twr_d = 1'b0;
        oe_d = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                // Strobes with select high are ignored
                if (!ce_n_s && !wr_strobe_n) begin
                    state_d = ST_WRITE;
                end else if (rd_req) begin
                    // Address taken on entry so the first driven word is already the right one
                    addr_d = target_of(add_s2_q);
                    state_d = ST_READ;
                end
            end
            ST_WRITE: begin
                // Address sampled at the rising strobe edge, data too when transfer select is low
                if (wr_strobe_n) begin
                    state_d = ST_IDLE;
                    addr_d = target_of(add_s2_q);
                    if (sel_s) begin
                        twr_d = 1'b1;
                    end else begin
                        hold_d = p_s2_q;
                        load_d = 1'b1;
                    end
                end
            end
            ST_READ: begin
                // Core data is followed every cycle, so a register that changes is seen live
                if (rd_req) begin
                    addr_d = target_of(add_s2_q);
                    rdata_d = READ_DATA;
                    oe_d = 1'b1;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_q <= ST_IDLE;
            hold_q <= HOLD_RESET;
            addr_q <= '0;
            rdata_q <= HOLD_RESET;
            load_q <= 1'b0;
            twr_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            hold_q <= hold_d;
            addr_q <= addr_d;
            rdata_q <= rdata_d;
            load_q <= load_d;
            twr_q <= twr_d;
            oe_q <= oe_d;
        end
    end

    // Bus drive is gated by the live synchronised request so it drops promptly
    assign P_OE = oe_q & rd_req;
    assign P_OUT = rdata_q;
    assign HOLD_DATA = hold_q;
    assign TARGET_ADDR = addr_q;
    assign HOLD_LOAD = load_q;
    assign TARGET_WRITE = twr_q;
    assign READ_ACTIVE = (state_q == ST_READ);

    // A retrigger restarts the count, so back-to-back events merge into one pulse
    pulse_stretch #(
        .WIDTH(PULSE_W)
    ) irq_stretch (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .trigger(NEW_DATA),
        .length(PULSE_LEN),
        .pulse(NEW_DATA_INTERRUPT)
    );
endmodule // host_processor_port

// >>> logic/host_port_pkg.sv
// Purpose: Constants and types shared by the parallel host port
// Assumes: Single clock at 100 MHz
// Notes: Pulse length of the new data interrupt is loaded from a port
package host_port_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 3;
    localparam int ADDR_USED_W = 2;
    localparam int PULSE_W = 8;
    localparam logic [15:0] HOLD_RESET = 16'h0000;
    localparam logic [7:0] PULSE_LEN_RESET = 8'h01;
    localparam logic [7:0] PULSE_COUNT_ZERO = 8'h00;
    localparam logic [7:0] PULSE_COUNT_ONE = 8'h01;
    // Idle pins after reset: mode low, select, write and read strobes high, transfer select low
    localparam logic [4:0] CTL_IDLE = 5'h0E;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WRITE = 2'b01,
        ST_READ = 2'b10
    } access_state_type;
endpackage

// >>> logic/pulse_stretch.sv
// Purpose: Stretch a one-cycle event into a pulse of programmable length
// Assumes: Length is held stable between events
// Notes: A new event during a pulse restarts the count
`timescale 1ns/10ps
module pulse_stretch
    import host_port_pkg::*;
#(
    parameter int WIDTH = PULSE_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic trigger,
    input wire logic [WIDTH-1:0] length,
    output logic pulse
);
    if (WIDTH < 1) begin : g_width_check
        $error("pulse_stretch WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;

    always_comb begin
        count_d = count_q;
        if (trigger) begin
            // Zero length still gives one cycle so the event is never lost
            count_d = (length == '0) ? WIDTH'(1) : length;
        end else if (count_q != '0) begin
            count_d = count_q - WIDTH'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    assign pulse = (count_q != '0);
endmodule // pulse_stretch

// >>> sim/host_port_properties.sv
// Purpose: Port-level properties of the parallel host port
// Assumes: Host holds pins steady 4 clocks around each strobe edge
// Notes: Pins pass a 2-stage synchroniser; drive sits 2 clocks back, captured write data 3
`timescale 1ns/10ps
module host_port_properties import host_port_pkg::*; (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic [DATA_W-1:0] P_IN,
    input wire logic P_OE,
    input wire logic [ADDR_W-1:0] ADD,
    input wire logic WR_N,
    input wire logic RD_N,
    input wire logic CE_N,
    input wire logic UP_MODE,
    input wire logic [DATA_W-1:0] HOLD_DATA,
    input wire logic [ADDR_USED_W-1:0] TARGET_ADDR,
    input wire logic HOLD_LOAD,
    input wire logic TARGET_WRITE,
    input wire logic NEW_DATA,
    input wire logic NEW_DATA_INTERRUPT
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    property p_oe_sel; P_OE |-> !$past(CE_N, 2); endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("bus driven without select");
    property p_rd_sep; P_OE && !UP_MODE |-> !$past(RD_N, 2); endproperty
    a_rd_sep: assert property (p_rd_sep) else $error("bus driven without read strobe");
    property p_rd_comb; P_OE && UP_MODE |-> $past(RD_N, 2) && !$past(WR_N, 2); endproperty
    a_rd_comb: assert property (p_rd_comb) else $error("bus driven without read strobe");
    property p_wr_edge; HOLD_LOAD || TARGET_WRITE |-> WR_N && $past(WR_N); endproperty
    a_wr_edge: assert property (p_wr_edge) else $error("write before strobe rose");
    property p_wr_data; HOLD_LOAD |-> HOLD_DATA == $past(P_IN, 3); endproperty
    a_wr_data: assert property (p_wr_data) else $error("holding data wrong");
    property p_wr_addr; HOLD_LOAD || TARGET_WRITE |-> TARGET_ADDR == ADDR_USED_W'($past(ADD, 3)); endproperty
    a_wr_addr: assert property (p_wr_addr) else $error("target address wrong");
    property p_pulse; HOLD_LOAD |-> !TARGET_WRITE ##1 !HOLD_LOAD; endproperty
    a_pulse: assert property (p_pulse) else $error("load pulse wrong");
    property p_irq; NEW_DATA |=> NEW_DATA_INTERRUPT; endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");
endmodule // host_port_properties

// >>> sim/host_cpu_model.sv
// Purpose: Host processor model driving the parallel port pins
// Assumes: Each strobe is held low 7 clocks and high at least 8 clocks
// Notes: A released bus shows the inverse of its last value
`timescale 1ns/10ps
module host_cpu_model (
    input wire logic clk,
    input wire logic mode,
    input wire logic [15:0] bus,
    output logic [15:0] drv,
    output logic [2:0] add,
    output logic wr_n,
    output logic rd_n,
    output logic ce_n,
    output logic xfer
);
    initial {drv, add, wr_n, rd_n, ce_n, xfer} = {16'h0000, 3'h0, 4'hE};
    task automatic access(input logic [2:0] a, input logic [15:0] d, input logic sel, input logic rd,
        input logic ce, output logic [15:0] q);
        @(posedge clk);
        {add, drv, xfer, ce_n} <= {a, d, sel, ce};
        {wr_n, rd_n} <= mode ? {1'b0, rd} : {rd, !rd};
        repeat (6) @(posedge clk);
        @(negedge clk);
        q = bus;
        @(posedge clk);
        {wr_n, rd_n} <= 2'b11;
        repeat (4) @(posedge clk);
        {drv, ce_n} <= {~d, 1'b1};
        repeat (3) @(posedge clk);
    endtask
endmodule // host_cpu_model

// >>> sim/testbench.sv
// Purpose: Self-checking bench for the parallel host port
// Assumes: Core read data is a fixed pattern of the target address
// Notes: Fixed waits follow the port latencies
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin errors++; $display("Error %s exp %h got %h", n, e, s); end end
module testbench import host_port_pkg::*; ;
    logic clk = 0, rst = 1, p_oe, wr_n, rd_n, ce_n, xsel, hl, tw, irq, ra, mode = 0, nd = 0;
    logic [15:0] p_out, bus, drv, hold, q;
    logic [2:0] add;
    logic [1:0] taddr;
    logic [7:0] plen = 8'h01;
    int errors = 0, checks = 0, hl_n = 0, tw_n = 0, oe_n = 0, irq_n = 0, ra_n = 0, b;
    assign bus = p_oe ? p_out : drv;
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        hl_n += hl;
        tw_n += tw;
        oe_n += p_oe;
        irq_n += irq;
        ra_n += ra;
    end
    host_cpu_model cpu_u (.clk(clk), .mode(mode), .bus(bus), .drv(drv), .add(add), .wr_n(wr_n), .rd_n(rd_n),
        .ce_n(ce_n), .xfer(xsel));
    host_processor_port dut_u (.REF_CLK(clk), .SYS_RST(rst), .P_IN(bus), .P_OUT(p_out), .P_OE(p_oe), .ADD(add),
        .WR_N(wr_n), .RD_N(rd_n), .CE_N(ce_n), .UP_MODE(mode), .XFER_SEL(xsel), .HOLD_DATA(hold),
        .TARGET_ADDR(taddr), .HOLD_LOAD(hl), .TARGET_WRITE(tw), .READ_DATA(16'hC3A0 ^ {14'h0000, taddr}),
        .READ_ACTIVE(ra), .NEW_DATA(nd), .PULSE_LEN(plen), .NEW_DATA_INTERRUPT(irq));
    task t_separate;
        cpu_u.access(3'h5, 16'hBEEF, 0, 0, 0, q);
        `CHK("hold", 16'hBEEF, hold)
        `CHK("taddr", 2'h1, taddr)
        `CHK("loads", 1, hl_n)
        cpu_u.access(3'h2, 16'h1234, 1, 0, 0, q);
        `CHK("target writes", 1, tw_n)
        cpu_u.access(3'h3, 16'h5555, 0, 0, 1, q);
        cpu_u.access(3'h2, 16'h3C5D, 0, 1, 1, q);
        `CHK("hold kept", 16'hBEEF, hold)
        `CHK("drive cycles", 0, oe_n)
        `CHK("read cycles", 0, ra_n)
        cpu_u.access(3'h6, 16'h3C5D, 0, 1, 0, q);
        `CHK("read", 16'hC3A2, q)
        `CHK("read cycles", 7, ra_n)
        `CHK("drive cycles", 5, oe_n)
        `CHK("taddr", 2'h2, taddr)
        $display("test separate done");
    endtask
    task t_combined;
        @(posedge clk) mode <= 1;
        cpu_u.access(3'h7, 16'hA5A5, 0, 0, 0, q);
        `CHK("hold", 16'hA5A5, hold)
        cpu_u.access(3'h1, 16'h3C5E, 0, 1, 0, q);
        `CHK("read", 16'hC3A1, q)
        `CHK("taddr", 2'h1, taddr)
        $display("test combined done");
    endtask
    task t_interrupt;
        for (int l = 0; l < 5; l += 2) begin
            @(posedge clk) plen <= 8'(l);
            b = irq_n;
            @(posedge clk) nd <= 1;
            @(posedge clk) nd <= 0;
            repeat (8) @(posedge clk);
            `CHK("interrupt cycles", (l ? l : 1), irq_n - b)
        end
        $display("test interrupt done");
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        t_separate;
        t_combined;
        t_interrupt;
        tally_and_finish;
    end
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        tally_and_finish;
    end
endmodule // testbench
bind host_processor_port host_port_properties chk_u (.*);
